// ### dv/rtc_i2c_checker.sv
// Bus watcher for the two-wire RTC register port
// Assumes wired levels of the bus and the slave's link clock and reset
`default_nettype none

module rtc_i2c_checker (
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe
);
  logic       scl_ff, sda_ff, first_ff, hit_ff, rd_ff, nack_ff;
  logic       nxt_first, nxt_hit, nxt_rd, nxt_nack, rise, ack_rise, edge_sp;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;

  ////////////////////////////////////////////////////////////////////////
  // Bit count, first byte and direction tracking
  always_comb begin
    rise      = scl & ~scl_ff;
    ack_rise  = rise & (cnt_ff == 4'h8);
    edge_sp   = scl & scl_ff & (sda != sda_ff);
    nxt_cnt   = rise ? (ack_rise ? 4'h0 : cnt_ff + 4'h1) : cnt_ff;
    nxt_sh    = (rise & ~ack_rise) ? {sh_ff[6:0], sda} : sh_ff;
    nxt_first = first_ff & ~ack_rise;
    nxt_hit   = (ack_rise & first_ff) ? (sh_ff[7:1] == rtc_i2c_pkg::DEV_ADDR) : hit_ff;
    nxt_rd    = (ack_rise & first_ff) ? sh_ff[0] : rd_ff;
    nxt_nack  = nack_ff | (ack_rise & ~first_ff & hit_ff & rd_ff & sda);
    if (edge_sp) begin
      nxt_cnt   = 4'h0;
      nxt_first = ~sda;
      nxt_hit   = 1'b0;
      nxt_nack  = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      {scl_ff, sda_ff} <= 2'h3;
      {cnt_ff, sh_ff, first_ff, hit_ff, rd_ff, nack_ff} <= '0;
    end else begin
      {scl_ff, sda_ff} <= {scl, sda};
      {cnt_ff, sh_ff, first_ff, hit_ff, rd_ff, nack_ff} <=
        {nxt_cnt, nxt_sh, nxt_first, nxt_hit, nxt_rd, nxt_nack};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus properties
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);

  sequence ack_low_s;
    ack_rise && !sda;
  endsequence

  a_addr_ack: assert property (
    ack_rise && first_ff && sh_ff[7:1] == rtc_i2c_pkg::DEV_ADDR |-> !sda)
    else $error("own address not acknowledged");
  a_addr_noack: assert property (
    ack_rise && first_ff && sh_ff[7:1] != rtc_i2c_pkg::DEV_ADDR |-> sda)
    else $error("foreign address acknowledged");
  a_write_ack: assert property (
    ack_rise && !first_ff && hit_ff && !rd_ff |-> !sda)
    else $error("written byte not acknowledged");
  a_ack_steady: assert property (
    ack_low_s |=> !sda until !scl)
    else $error("acknowledge not held low");
  a_ack_bound: assert property (
    ack_low_s |-> ##[1:100] !scl)
    else $error("acknowledge clock too long");
  a_hold_high: assert property (
    scl && scl_ff |-> $stable(s_sda_oe))
    else $error("slave drive changed with clock high");
  a_stranger_quiet: assert property (
    !first_ff && !hit_ff |-> !s_sda_oe)
    else $error("slave drives while not addressed");
  a_nack_quiet: assert property (
    nack_ff |-> !s_sda_oe)
    else $error("slave drives after no-ack");
  a_ack_slot: assert property (
    $rose(s_sda_oe) && (first_ff || !rd_ff) |-> cnt_ff == 4'h8)
    else $error("slave drive outside the ack slot");
  a_read_ack_free: assert property (
    ack_rise && !first_ff && hit_ff && rd_ff |-> !s_sda_oe)
    else $error("slave drives during master ack");
endmodule

`default_nettype wire

// ### dv/tb_rtc_i2c_slave_register_port.sv
// Bench joining master and slave ends over one bus, with a register model
// Assumes the package and interface compile first
`default_nettype none

module tb_rtc_i2c_slave_register_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk = 1'b0;
  logic             link_clk = 1'b0;
  logic             rst_n;
  logic             link_rst_n;
  logic             cmd_valid;
  logic             cmd_ready;
  rtc_i2c_pkg::op_t cmd_op;
  logic [7:0]       cmd_data;
  logic             cmd_last;
  logic             rsp_valid;
  logic [7:0]       rsp_data;
  logic             rsp_nack;
  logic [3:0]       reg_addr;
  logic [7:0]       reg_rd_data;
  logic             reg_wr_stb;
  logic [3:0]       reg_wr_addr;
  logic [7:0]       reg_wr_data;
  logic             reg_rd_stb;
  logic             busy;
  logic             bus_held;
  logic [7:0]       regs [16];
  int               exp_regs [16];
  int               exp_ptr;
  logic [11:0]      wq [$];
  int               err_count;
  int               total_checks;
  int               rd_loads;

  always #10 core_clk = ~core_clk;
  always #15 link_clk = ~link_clk;

  rtc_i2c_if bus_if ();

  rtc_i2c_master i_rtc_i2c_master (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .bus       (bus_if),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_op    (cmd_op),
    .cmd_data  (cmd_data),
    .cmd_last  (cmd_last),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data),
    .rsp_nack  (rsp_nack),
    .bus_held  (bus_held)
  );

  rtc_i2c_slave i_rtc_i2c_slave (
    .link_clk    (link_clk),
    .link_rst_n  (link_rst_n),
    .bus         (bus_if),
    .reg_addr    (reg_addr),
    .reg_rd_data (reg_rd_data),
    .reg_rd_stb  (reg_rd_stb),
    .reg_wr_stb  (reg_wr_stb),
    .reg_wr_addr (reg_wr_addr),
    .reg_wr_data (reg_wr_data),
    .busy        (busy)
  );

  rtc_i2c_checker u_watch (
    .link_clk   (link_clk),
    .link_rst_n (link_rst_n),
    .scl        (bus_if.scl),
    .sda        (bus_if.sda),
    .s_sda_oe   (bus_if.s_sda_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // User register file and write monitor
  assign reg_rd_data = regs[reg_addr];

  always @(posedge link_clk) begin
    if (reg_rd_stb === 1'b1)
      rd_loads++;
    if (reg_wr_stb === 1'b1) begin
      regs[reg_wr_addr] <= reg_wr_data;
      chk("write expected", 12'(wq.size() != 0), 12'h1);
      if (wq.size() != 0)
        chk("reg write", {reg_wr_addr, reg_wr_data}, wq.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmd(input rtc_i2c_pkg::op_t op, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_last = l;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 4000) begin
      err_count++;
      close_out();
    end
    // Let the slave see the STOP
    if (op == rtc_i2c_pkg::OP_STOP)
      repeat (10) @(negedge core_clk);
    chk("bus held", 12'(bus_held), 12'(op != rtc_i2c_pkg::OP_STOP));
    chk("slave busy", 12'(busy), 12'(op != rtc_i2c_pkg::OP_STOP));
  endtask

  task automatic wr_xfer(input int ptr, input int n);
    logic [7:0] d;
    cmd(rtc_i2c_pkg::OP_START, rtc_i2c_pkg::ADDR_WR, 1'b0);
    chk("addr ack", 12'(rsp_nack), 12'h0);
    d = 8'($urandom);
    cmd(rtc_i2c_pkg::OP_WRITE, {d[7:4], 4'(ptr)}, 1'b0);
    chk("ptr ack", 12'(rsp_nack), 12'h0);
    exp_ptr = ptr;
    repeat (n) begin
      d = 8'($urandom);
      wq.push_back({4'(exp_ptr), d});
      exp_regs[exp_ptr] = d;
      exp_ptr = (exp_ptr + 1) % 16;
      cmd(rtc_i2c_pkg::OP_WRITE, d, 1'b0);
      chk("data ack", 12'(rsp_nack), 12'h0);
    end
    // Bare pointer write: the next START stops first
    if (n > 0)
      cmd(rtc_i2c_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic rd_xfer(input int n);
    rd_loads = 0;
    cmd(rtc_i2c_pkg::OP_START, rtc_i2c_pkg::ADDR_RD, 1'b0);
    chk("read addr ack", 12'(rsp_nack), 12'h0);
    for (int i = 1; i <= n; i++) begin
      cmd(rtc_i2c_pkg::OP_READ, 8'h00, 1'(i == n));
      chk("read data", 12'(rsp_data), 12'(exp_regs[exp_ptr]));
      chk("master ack", 12'(rsp_nack), 12'(i == n));
      exp_ptr = (exp_ptr + 1) % 16;
    end
    cmd(rtc_i2c_pkg::OP_STOP, 8'h00, 1'b0);
    chk("read loads", 12'(rd_loads), 12'(n));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] a;
    void'($urandom(32'h49c6abe4));
    {rst_n, link_rst_n, cmd_valid, cmd_data, cmd_last} = '0;
    cmd_op = rtc_i2c_pkg::OP_START;
    err_count = 0;
    total_checks = 0;
    foreach (regs[i]) begin
      regs[i] = 8'($urandom);
      exp_regs[i] = regs[i];
    end
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    wr_xfer(4, 5);
    wr_xfer(2, 0);
    rd_xfer(3);
    rd_xfer(2);
    repeat (3) begin
      a = 8'($urandom);
      if (a[7:1] == rtc_i2c_pkg::DEV_ADDR)
        a[6] = ~a[6];
      cmd(rtc_i2c_pkg::OP_START, a, 1'b0);
      chk("foreign ack", 12'(rsp_nack), 12'h1);
      cmd(rtc_i2c_pkg::OP_WRITE, 8'($urandom), 1'b0);
      chk("ignored ack", 12'(rsp_nack), 12'h1);
      cmd(rtc_i2c_pkg::OP_STOP, 8'h00, 1'b0);
    end
    rd_xfer(1);
    wr_xfer(9, 2);
    rd_xfer(2);
    chk("writes left", 12'(wq.size()), 12'h0);
    close_out();
  end
endmodule

`default_nettype wire

// ### inc/rtc_i2c_if.sv
// Two-wire bus carrier joining master and slave ends
// Assumes open-drain pins with pull-ups; a released line reads high
`default_nettype none

interface rtc_i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // Wired-and of all drivers
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input  scl,
    input  sda
  );

  modport slave (
    output s_sda_o,
    output s_sda_oe,
    input  scl,
    input  sda
  );
endinterface

`default_nettype wire

// ### inc/rtc_i2c_pkg.sv
// Shared constants and types for the two-wire RTC register port
// Assumes both ends and the bench compile this package first
`default_nettype none

package rtc_i2c_pkg;
  localparam logic [6:0]  DEV_ADDR       = 7'h68;
  localparam logic [7:0]  ADDR_WR        = 8'hd0;
  localparam logic [7:0]  ADDR_RD        = 8'hd1;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam logic [3:0]  PTR_ONE        = 4'h1;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam int          CORE_PERIOD_NS = 20;
  localparam int          SCL_QTR_NS     = 625;
  localparam int          SCL_QTR_CYC    = (SCL_QTR_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int          DIV_W          = 6;
  localparam logic [5:0]  DIV_LAST       = 6'(SCL_QTR_CYC - 1);
  localparam logic [5:0]  DIV_ONE        = 6'h01;
  localparam logic [1:0]  Q_START_SDA    = 2'h1;
  localparam logic [1:0]  Q_LAST         = 2'h3;
  localparam logic [1:0]  Q_SCL_HIGH     = 2'h1;
  localparam logic [1:0]  Q_SAMPLE       = 2'h2;
  localparam logic [1:0]  Q_SET_DATA     = 2'h0;
  localparam logic [1:0]  Q_ONE          = 2'h1;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ  = 2'h2,
    OP_STOP  = 2'h3
  } op_t;
endpackage

`default_nettype wire

// ### logic/rtc_i2c_master.sv
// Master end of the RTC register port: SCL divider and byte-level commands
// Assumes one command at a time; no clock stretching by the slave
`default_nettype none

module rtc_i2c_master (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  rtc_i2c_if.master               bus,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire rtc_i2c_pkg::op_t   cmd_op,
  input  wire logic [7:0]         cmd_data,
  input  wire logic               cmd_last,
  output logic                    rsp_valid,
  output logic [7:0]              rsp_data,
  output logic                    rsp_nack,
  output logic                    bus_held
);

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h3,
    H_STOP  = 2'h2
  } host_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // SDA synchroniser and quarter-period divider

  logic sda_m_ff;
  logic sda_s_ff;
  logic [rtc_i2c_pkg::DIV_W-1:0] div_ff;
  logic [rtc_i2c_pkg::DIV_W-1:0] nxt_div;
  logic tick;

  assign tick = (div_ff == rtc_i2c_pkg::DIV_LAST);

  always_comb begin
    nxt_div = tick ? '0 : div_ff + rtc_i2c_pkg::DIV_ONE;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      div_ff   <= '0;
    end else begin
      sda_m_ff <= bus.sda;
      sda_s_ff <= sda_m_ff;
      div_ff   <= nxt_div;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  host_state_t st_ff;
  host_state_t nxt_st;
  logic [1:0]  q_ff;
  logic [1:0]  nxt_q;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic [8:0]  sh_ff;
  logic [8:0]  nxt_sh;
  logic [8:0]  rx_ff;
  logic [8:0]  nxt_rx;
  logic        scl_ff;
  logic        nxt_scl;
  logic        sda_ff;
  logic        nxt_sda;
  logic        held_ff;
  logic        nxt_held;
  logic        pend_ff;
  logic        nxt_pend;
  logic        rsp_ff;
  logic        nxt_rsp;

  assign cmd_ready = (st_ff == H_IDLE);

  always_comb begin
    nxt_st   = st_ff;
    nxt_q    = q_ff;
    nxt_bit  = bit_ff;
    nxt_sh   = sh_ff;
    nxt_rx   = rx_ff;
    nxt_scl  = scl_ff;
    nxt_sda  = sda_ff;
    nxt_held = held_ff;
    nxt_pend = pend_ff;
    nxt_rsp  = 1'b0;
    if (st_ff != H_IDLE && tick) begin
      nxt_q = q_ff + rtc_i2c_pkg::Q_ONE;
    end
    unique case (st_ff)
      H_IDLE: begin
        if (cmd_valid) begin
          nxt_bit = rtc_i2c_pkg::CNT_ZERO;
          unique case (cmd_op)
            rtc_i2c_pkg::OP_START: begin
              nxt_sh = {cmd_data, 1'b1};
              if (held_ff) begin
                // Close the open transfer before a new START
                nxt_pend = 1'b1;
                nxt_st   = H_STOP;
              end else begin
                nxt_st = H_START;
              end
            end
            rtc_i2c_pkg::OP_WRITE: begin
              nxt_sh = {cmd_data, 1'b1};
              nxt_st = H_BIT;
            end
            rtc_i2c_pkg::OP_READ: begin
              // Ack all but the final byte
              nxt_sh = {8'hff, cmd_last};
              nxt_st = H_BIT;
            end
            rtc_i2c_pkg::OP_STOP: begin
              if (held_ff) begin
                nxt_st = H_STOP;
              end else begin
                nxt_rsp = 1'b1;
              end
            end
          endcase
        end
      end
      H_START: begin
        if (tick && q_ff == rtc_i2c_pkg::Q_START_SDA) begin
          nxt_sda = 1'b0;
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_LAST) begin
          nxt_scl  = 1'b0;
          nxt_held = 1'b1;
          nxt_st   = H_BIT;
        end
      end
      H_BIT: begin
        if (tick && q_ff == rtc_i2c_pkg::Q_SET_DATA) begin
          nxt_sda = sh_ff[8];
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_SCL_HIGH) begin
          nxt_scl = 1'b1;
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_SAMPLE) begin
          nxt_rx = {rx_ff[7:0], sda_s_ff};
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_LAST) begin
          nxt_scl = 1'b0;
          nxt_sh  = {sh_ff[7:0], 1'b1};
          nxt_bit = bit_ff + rtc_i2c_pkg::CNT_ONE;
          if (bit_ff == rtc_i2c_pkg::BYTE_BITS) begin
            nxt_rsp = 1'b1;
            nxt_st  = H_IDLE;
          end
        end
      end
      H_STOP: begin
        if (tick && q_ff == rtc_i2c_pkg::Q_SET_DATA) begin
          nxt_sda = 1'b0;
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_SCL_HIGH) begin
          nxt_scl = 1'b1;
        end
        if (tick && q_ff == rtc_i2c_pkg::Q_LAST) begin
          nxt_sda  = 1'b1;
          nxt_held = 1'b0;
          if (pend_ff) begin
            nxt_pend = 1'b0;
            nxt_st   = H_START;
          end else begin
            nxt_rsp = 1'b1;
            nxt_st  = H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff   <= H_IDLE;
      q_ff    <= 2'h0;
      bit_ff  <= 4'h0;
      sh_ff   <= 9'h1ff;
      rx_ff   <= 9'h000;
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
      held_ff <= 1'b0;
      pend_ff <= 1'b0;
      rsp_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      q_ff    <= nxt_q;
      bit_ff  <= nxt_bit;
      sh_ff   <= nxt_sh;
      rx_ff   <= nxt_rx;
      scl_ff  <= nxt_scl;
      sda_ff  <= nxt_sda;
      held_ff <= nxt_held;
      pend_ff <= nxt_pend;
      rsp_ff  <= nxt_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = ~scl_ff;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = ~sda_ff;
  assign rsp_valid    = rsp_ff;
  assign rsp_data     = rx_ff[8:1];
  assign rsp_nack     = rx_ff[0];
  assign bus_held     = held_ff;

endmodule

`default_nettype wire

// ### logic/rtc_i2c_slave.sv
// Slave end of the RTC register port: address match, pointer, byte shifting
// Assumes link_clk runs free and is much faster than SCL; the user register
// file answers reg_rd_data combinationally from reg_addr
`default_nettype none

module rtc_i2c_slave (
  input  wire logic       link_clk,
  input  wire logic       link_rst_n,
  rtc_i2c_if.slave        bus,
  output logic [3:0]      reg_addr,
  input  wire logic [7:0] reg_rd_data,
  output logic            reg_rd_stb,
  output logic            reg_wr_stb,
  output logic [3:0]      reg_wr_addr,
  output logic [7:0]      reg_wr_data,
  output logic            busy
);

  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_AACK = 4'h3,
    D_PTR  = 4'h2,
    D_PACK = 4'h6,
    D_WDAT = 4'h7,
    D_WACK = 4'h5,
    D_RDAT = 4'h4,
    D_RACK = 4'hc,
    D_IGN  = 4'hd
  } dev_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic scl_m_ff;
  logic scl_s_ff;
  logic scl_q_ff;
  logic sda_m_ff;
  logic sda_s_ff;
  logic sda_q_ff;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_m_ff <= bus.scl;
      scl_s_ff <= scl_m_ff;
      scl_q_ff <= scl_s_ff;
      sda_m_ff <= bus.sda;
      sda_s_ff <= sda_m_ff;
      sda_q_ff <= sda_s_ff;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  // Bus conditions
  assign start_det = scl_s_ff & scl_q_ff & sda_q_ff & ~sda_s_ff;
  assign stop_det  = scl_s_ff & scl_q_ff & ~sda_q_ff & sda_s_ff;
  assign scl_rise  = scl_s_ff & ~scl_q_ff;
  assign scl_fall  = ~scl_s_ff & scl_q_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state

  dev_state_t st_ff;
  dev_state_t nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [3:0] ptr_ff;
  logic [3:0] nxt_ptr;
  logic       low_ff;
  logic       nxt_low;
  logic       rw_ff;
  logic       nxt_rw;
  logic       mack_ff;
  logic       nxt_mack;
  logic       wr_stb_ff;
  logic       nxt_wr_stb;
  logic [3:0] wr_addr_ff;
  logic [3:0] nxt_wr_addr;
  logic [7:0] wr_data_ff;
  logic [7:0] nxt_wr_data;
  logic       rd_load;

  always_comb begin
    nxt_st      = st_ff;
    nxt_sh      = sh_ff;
    nxt_cnt     = cnt_ff;
    nxt_ptr     = ptr_ff;
    nxt_low     = low_ff;
    nxt_rw      = rw_ff;
    nxt_mack    = mack_ff;
    nxt_wr_stb  = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    rd_load     = 1'b0;
    if (start_det) begin
      // Any START restarts addressing
      nxt_st  = D_ADDR;
      nxt_cnt = rtc_i2c_pkg::CNT_ZERO;
      nxt_low = 1'b0;
    end else if (stop_det) begin
      nxt_st  = D_IDLE;
      nxt_low = 1'b0;
    end else begin
      unique case (st_ff)
        D_IDLE, D_IGN: begin
          nxt_low = 1'b0;
        end
        D_ADDR, D_PTR, D_WDAT: begin
          if (scl_rise && cnt_ff != rtc_i2c_pkg::BYTE_BITS) begin
            // Shift in MSB first
            nxt_sh  = {sh_ff[6:0], sda_s_ff};
            nxt_cnt = cnt_ff + rtc_i2c_pkg::CNT_ONE;
          end
          if (scl_fall && cnt_ff == rtc_i2c_pkg::BYTE_BITS) begin
            // Byte complete: pull SDA low for the ack clock, except after a foreign address
            nxt_low = 1'b1;
            if (st_ff == D_ADDR) begin
              if (sh_ff[7:1] == rtc_i2c_pkg::DEV_ADDR) begin
                nxt_rw = sh_ff[0];
                nxt_st = D_AACK;
              end else begin
                nxt_low = 1'b0;
                nxt_st  = D_IGN;
              end
            end else if (st_ff == D_PTR) begin
              nxt_ptr = sh_ff[3:0];
              nxt_st  = D_PACK;
            end else begin
              // Store at pointer, then advance
              nxt_wr_stb  = 1'b1;
              nxt_wr_addr = ptr_ff;
              nxt_wr_data = sh_ff;
              nxt_ptr     = ptr_ff + rtc_i2c_pkg::PTR_ONE;
              nxt_st      = D_WACK;
            end
          end
        end
        D_AACK, D_PACK, D_WACK: begin
          if (scl_fall) begin
            nxt_low = 1'b0;
            nxt_cnt = rtc_i2c_pkg::CNT_ZERO;
            if (st_ff == D_AACK && rw_ff) begin
              rd_load = 1'b1;
            end else if (st_ff == D_AACK) begin
              nxt_st = D_PTR;
            end else begin
              nxt_st = D_WDAT;
            end
          end
        end
        D_RDAT: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + rtc_i2c_pkg::CNT_ONE;
          end
          if (scl_fall) begin
            if (cnt_ff == rtc_i2c_pkg::BYTE_BITS) begin
              // Release for the master's ack bit
              nxt_low = 1'b0;
              nxt_st  = D_RACK;
            end else begin
              nxt_sh  = {sh_ff[6:0], 1'b1};
              nxt_low = ~sh_ff[6];
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            nxt_mack = ~sda_s_ff;
          end
          if (scl_fall) begin
            if (mack_ff) begin
              rd_load = 1'b1;
            end else begin
              // No-ack ends the read: stay off SDA until STOP
              nxt_low = 1'b0;
              nxt_st  = D_IGN;
            end
          end
        end
        default: begin
          nxt_st  = D_IDLE;
          nxt_low = 1'b0;
        end
      endcase
      if (rd_load) begin
        // Load byte at pointer and drive its MSB
        nxt_sh  = reg_rd_data;
        nxt_low = ~reg_rd_data[7];
        nxt_cnt = rtc_i2c_pkg::CNT_ZERO;
        nxt_ptr = ptr_ff + rtc_i2c_pkg::PTR_ONE;
        nxt_st  = D_RDAT;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      st_ff      <= D_IDLE;
      sh_ff      <= 8'h00;
      cnt_ff     <= 4'h0;
      ptr_ff     <= 4'h0;
      low_ff     <= 1'b0;
      rw_ff      <= 1'b0;
      mack_ff    <= 1'b0;
      wr_stb_ff  <= 1'b0;
      wr_addr_ff <= 4'h0;
      wr_data_ff <= 8'h00;
    end else begin
      st_ff      <= nxt_st;
      sh_ff      <= nxt_sh;
      cnt_ff     <= nxt_cnt;
      ptr_ff     <= nxt_ptr;
      low_ff     <= nxt_low;
      rw_ff      <= nxt_rw;
      mack_ff    <= nxt_mack;
      wr_stb_ff  <= nxt_wr_stb;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = low_ff;
  assign reg_addr     = ptr_ff;
  assign reg_rd_stb   = rd_load;
  assign reg_wr_stb   = wr_stb_ff;
  assign reg_wr_addr  = wr_addr_ff;
  assign reg_wr_data  = wr_data_ff;
  assign busy         = (st_ff != D_IDLE);

endmodule

`default_nettype wire
